/* common/ssw_pkg.sv */
package ssw_pkg;
   localparam int unsigned WORD_BITS     = 24;
   localparam int unsigned BYTE_BITS     = 8;
   localparam int unsigned BYTES_PER_WD  = 3;
   localparam int unsigned CTRL_BITS     = 3;
   localparam int unsigned NUM_LATCHES   = 8;
   localparam int unsigned INT_LSB       = 3;
   localparam int unsigned INT_BITS      = 12;
   localparam int unsigned PRESC_BIT     = 15;
   localparam int unsigned MUX_LSB       = 16;
   localparam int unsigned MUX_BITS      = 2;
   localparam logic [2:0]  INT_LATCH     = 3'h0;
   localparam logic [2:0]  CFG_LATCH     = 3'h3;
   localparam logic [1:0]  MUX_LOCK      = 2'h1;
   localparam logic [1:0]  MUX_HIGH      = 2'h2;
   localparam logic [11:0] NMIN_P45      = 12'h01f;
   localparam logic [11:0] NMIN_P89      = 12'h05b;
   localparam int unsigned SYS_CLK_MHZ   = 250;
   localparam int unsigned SCLK_MAX_MHZ  = 20;
   // half serial period in system cycles, rounded up (least time)
   localparam int unsigned SCLK_HALF_CYC =
      (SYS_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
   localparam logic [3:0]  HALF_CNT      = 4'(SCLK_HALF_CYC);
   localparam logic [4:0]  BIT_LAST      = 5'(WORD_BITS - 1);
   typedef enum logic [1:0] {SSW_IDLE, SSW_LOW, SSW_HIGH, SSW_DONE} ssw_st_e;

   // least legal integer value for the chosen prescaler
   function automatic logic [11:0] ssw_nmin(input logic presc89);
      ssw_nmin = presc89 ? NMIN_P89 : NMIN_P45;
   endfunction : ssw_nmin
endpackage : ssw_pkg

/* common/ssw_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ssw_if;
   logic serial_clk;
   logic serial_data_in;
   logic latch_strobe;
   logic chip_enable;
   logic multiplexed_status_out;
   modport dev  (input serial_clk, serial_data_in, latch_strobe, chip_enable,
                 output multiplexed_status_out);
   modport host (output serial_clk, serial_data_in, latch_strobe, chip_enable,
                 input multiplexed_status_out);
endinterface : ssw_if
`default_nettype wire

/* design/ssw_device.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_device (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_clk_en,
   ssw_if.dev               link,
   input  wire logic        i_pll_locked,
   output logic [23:0]      o_latch_word,
   output logic [2:0]       o_latch_sel,
   output logic             o_latch_load,
   output logic             o_powered_down,
   output logic [11:0]      o_int_value,
   output logic             o_prescaler89,
   output logic             o_int_illegal
);
   // two-flop synchronisers for the link pins
   logic [1:0] sclk_s_q, data_s_q, le_s_q, ce_s_q;
   logic       sclk_d1_q, le_d1_q;
   logic [23:0] shift_q;
   logic [23:0] latch_q [ssw_pkg::NUM_LATCHES];
   logic        load_q;
   logic        pd_q;
   logic [1:0]  lock_s_q;                  // lock input comes from the loop
   logic        status_q;

   wire sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
   wire le_rise   = le_s_q[1] & ~le_d1_q;
   wire [2:0] sel = shift_q[ssw_pkg::CTRL_BITS-1:0];
   wire [23:0] int_word = latch_q[ssw_pkg::INT_LATCH];
   wire [23:0] cfg_word = latch_q[ssw_pkg::CFG_LATCH];
   wire [1:0] mux_sel = cfg_word[ssw_pkg::MUX_LSB +: ssw_pkg::MUX_BITS];
   // status select: lock detect when so configured, low in power-down
   wire status_d = ~pd_q &
      ((mux_sel == ssw_pkg::MUX_LOCK) ? lock_s_q[1] :
       (mux_sel == ssw_pkg::MUX_HIGH));

   // sync pins, track edges
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sclk_s_q  <= 2'h0;
         data_s_q  <= 2'h0;
         le_s_q    <= 2'h3;
         ce_s_q    <= 2'h0;
         sclk_d1_q <= 1'b0;
         le_d1_q   <= 1'b1;
      end else if (i_clk_en) begin
         sclk_s_q  <= {sclk_s_q[0], link.serial_clk};
         data_s_q  <= {data_s_q[0], link.serial_data_in};
         le_s_q    <= {le_s_q[0], link.latch_strobe};
         ce_s_q    <= {ce_s_q[0], link.chip_enable};
         sclk_d1_q <= sclk_s_q[1];
         le_d1_q   <= le_s_q[1];
      end
   end

   // shift register and latches; no strobe rise leaves latches alone
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shift_q <= 24'h0;
         load_q  <= 1'b0;
         pd_q    <= 1'b1;
         for (int i = 0; i < ssw_pkg::NUM_LATCHES; i++) begin
            latch_q[i] <= 24'h0;
         end
      end else if (i_clk_en) begin
         pd_q   <= ~ce_s_q[1];
         load_q <= le_rise;
         if (sclk_rise) begin
            shift_q <= {shift_q[ssw_pkg::WORD_BITS-2:0], data_s_q[1]};
         end
         if (le_rise) begin
            latch_q[sel] <= shift_q;
         end
      end
   end

   // register word as handed on to the synthesizer
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_latch_word <= 24'h0;
         o_latch_sel  <= 3'h0;
      end else if (i_clk_en && le_rise) begin
         o_latch_word <= shift_q;
         o_latch_sel  <= sel;
      end
   end

   // lock input synchroniser and registered status pin
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lock_s_q <= 2'h0;
         status_q <= 1'b0;
      end else if (i_clk_en) begin
         lock_s_q <= {lock_s_q[0], i_pll_locked};
         status_q <= status_d;
      end
   end

   assign o_latch_load   = load_q;
   assign o_powered_down = pd_q;
   assign o_int_value    = int_word[ssw_pkg::INT_LSB +: ssw_pkg::INT_BITS];
   assign o_prescaler89  = cfg_word[ssw_pkg::PRESC_BIT];
   // flag integer values below the prescaler minimum
   assign o_int_illegal  =
      o_int_value < ssw_pkg::ssw_nmin(o_prescaler89);
   // status pin comes straight from its flip-flop
   assign link.multiplexed_status_out = status_q;
endmodule : ssw_device
`default_nettype wire

/* design/ssw_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_host (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_clk_en,
   ssw_if.host              link,
   input  wire logic        i_start,
   input  wire logic [23:0] i_word,
   input  wire logic        i_power_down,
   output logic             o_busy,
   output logic             o_done,
   output logic             o_locked
);
   ssw_pkg::ssw_st_e st_q, st_d;
   logic [23:0] sh_q;
   logic [4:0]  bit_q;
   logic [3:0]  cnt_q;
   logic        sclk_q, le_q, ce_q, done_q;
   logic [1:0]  lock_s_q;

   wire half_end = (cnt_q == ssw_pkg::HALF_CNT - 4'h1);
   wire last_bit = (bit_q == ssw_pkg::BIT_LAST);

   // next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         ssw_pkg::SSW_IDLE: if (i_start) st_d = ssw_pkg::SSW_LOW;
         ssw_pkg::SSW_LOW:  if (half_end) st_d = ssw_pkg::SSW_HIGH;
         ssw_pkg::SSW_HIGH: begin
            if (half_end) st_d = last_bit ? ssw_pkg::SSW_DONE :
                                            ssw_pkg::SSW_LOW;
         end
         ssw_pkg::SSW_DONE: if (half_end) st_d = ssw_pkg::SSW_IDLE;
         default:           st_d = ssw_pkg::SSW_IDLE;
      endcase
   end

   // shift out msb first, data changes while clock low
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q   <= ssw_pkg::SSW_IDLE;
         sh_q   <= 24'h0;
         bit_q  <= 5'h0;
         cnt_q  <= 4'h0;
         sclk_q <= 1'b0;
         le_q   <= 1'b1;
         ce_q   <= 1'b0;
         done_q <= 1'b0;
         lock_s_q <= 2'h0;
      end else if (i_clk_en) begin
         st_q     <= st_d;
         ce_q     <= ~i_power_down;
         lock_s_q <= {lock_s_q[0], link.multiplexed_status_out};
         done_q   <= 1'b0;
         cnt_q    <= (st_q == ssw_pkg::SSW_IDLE || half_end) ? 4'h0 :
                     cnt_q + 4'h1;
         if (st_q == ssw_pkg::SSW_IDLE && i_start) begin
            sh_q  <= i_word;
            bit_q <= 5'h0;
            le_q  <= 1'b0;
         end
         if (st_q == ssw_pkg::SSW_LOW && half_end) begin
            sclk_q <= 1'b1;
         end
         if (st_q == ssw_pkg::SSW_HIGH && half_end) begin
            sclk_q <= 1'b0;
            sh_q   <= {sh_q[ssw_pkg::WORD_BITS-2:0], 1'b0};
            bit_q  <= bit_q + 5'h1;
         end
         if (st_q == ssw_pkg::SSW_DONE && half_end) begin
            le_q   <= 1'b1;
            done_q <= 1'b1;
         end
      end
   end

   assign link.serial_clk     = sclk_q;
   assign link.serial_data_in = sh_q[ssw_pkg::WORD_BITS-1];
   assign link.latch_strobe   = le_q;
   assign link.chip_enable    = ce_q;
   assign o_busy   = (st_q != ssw_pkg::SSW_IDLE);
   assign o_done   = done_q;
   assign o_locked = lock_s_q[1];
endmodule : ssw_host
`default_nettype wire

/* test/ssw_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_link_properties (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic latch_strobe,
   input wire logic chip_enable,
   input wire logic multiplexed_status_out
);
   logic       prev_q;
   logic [4:0] rises_q;
   // count serial clock rises inside a word
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prev_q  <= 1'b0;
         rises_q <= 5'h00;
      end else begin
         prev_q <= serial_clk;
         if (latch_strobe)
            rises_q <= 5'h00;
         else if (serial_clk && !prev_q)
            rises_q <= rises_q + 5'h01;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   a_data_steady: assert property
      ($rose(serial_clk) |-> $stable(serial_data_in)) else $error("data moved");
   a_high_half: assert property
      ($rose(serial_clk) |-> serial_clk[*7] ##1 !serial_clk)
      else $error("high half wrong");
   a_low_half: assert property
      ($fell(serial_clk) |-> !serial_clk[*7]) else $error("low half short");
   a_lead_in: assert property
      ($fell(latch_strobe) |-> !serial_clk[*7]) else $error("lead in short");
   a_idle_clock: assert property
      (latch_strobe |-> !serial_clk) else $error("clock outside word");
   a_word_count: assert property
      ($rose(latch_strobe) |-> rises_q == 5'h18) else $error("bit count");
   a_word_bound: assert property
      ($fell(latch_strobe) |-> ##[300:400] latch_strobe)
      else $error("word too long");
   a_pd_status: assert property
      (!chip_enable [*6] |-> !multiplexed_status_out)
      else $error("status in power down");
endmodule : ssw_link_properties
`default_nettype wire

/* test/ssw_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module synth_serial_write_port_tb;
   logic        clk = 1'b0;
   logic        cke = 1'b1;
   logic        rst_n = 1'b0;
   logic        start = 1'b0;
   logic        pdn = 1'b0;
   logic        lk_in = 1'b0;
   logic [23:0] word = 24'h000000;
   logic        busy, done, lk, load, pd, p89, bad;
   logic [23:0] lw;
   logic [2:0]  ls;
   logic [11:0] iv;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   ssw_if i_ssw_if ();
   ssw_host i_ssw_host (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(cke),
      .link(i_ssw_if), .i_start(start), .i_word(word), .i_power_down(pdn),
      .o_busy(busy), .o_done(done), .o_locked(lk));
   ssw_device i_ssw_device (.i_sys_clk(clk), .i_reset_n(rst_n),
      .i_clk_en(cke), .link(i_ssw_if), .i_pll_locked(lk_in),
      .o_latch_word(lw), .o_latch_sel(ls), .o_latch_load(load),
      .o_powered_down(pd), .o_int_value(iv), .o_prescaler89(p89),
      .o_int_illegal(bad));
   ssw_link_properties i_ssw_link_properties (.i_sys_clk(clk),
      .i_reset_n(rst_n), .serial_clk(i_ssw_if.serial_clk),
      .serial_data_in(i_ssw_if.serial_data_in),
      .latch_strobe(i_ssw_if.latch_strobe),
      .chip_enable(i_ssw_if.chip_enable),
      .multiplexed_status_out(i_ssw_if.multiplexed_status_out));
   // clock and hang guard
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [23:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic send(input logic [23:0] w);
      int   n;
      logic saw_done;
      n = 0;
      saw_done = 1'b0;
      @(negedge clk);
      word = w;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      chk("busy", {23'h0, busy}, 24'h000001);
      while (load !== 1'b1 && n < 500) begin
         if (done === 1'b1) begin
            saw_done = 1'b1;
         end
         @(negedge clk);
         n++;
      end
      chk("word", lw, w);
      chk("index", {21'h0, ls}, {21'h0, w[2:0]});
      chk("done", {23'h0, saw_done}, 24'h000001);
      chk("idle", {23'h0, busy}, 24'h000000);
   endtask : send
   task automatic settle;
      repeat (8) @(negedge clk);
   endtask : settle
   task automatic t_latches;
      for (int i = 0; i < 8; i++)
         send({i[7:0], 13'h1b3d, i[2:0]});
      $display("latch test done");
   endtask : t_latches
   task automatic t_limits;
      logic [12:0] tab [4] = '{13'h001e, 13'h001f, 13'h105a, 13'h105b};
      for (int i = 0; i < 4; i++) begin
         send({8'h00, tab[i][12], 12'h000, 3'h3});
         send({9'h000, tab[i][11:0], 3'h0});
         chk("int", {12'h0, iv}, {12'h0, tab[i][11:0]});
         chk("presc", {23'h0, p89}, {23'h0, tab[i][12]});
         chk("illegal", {23'h0, bad}, {23'h0, ~i[0]});
      end
      $display("limit test done");
   endtask : t_limits
   task automatic t_lock;
      send({6'h00, 2'h1, 13'h0000, 3'h3});
      lk_in = 1'b1;
      settle();
      chk("lock up", {23'h0, lk}, 24'h000001);
      lk_in = 1'b0;
      settle();
      chk("lock down", {23'h0, lk}, 24'h000000);
      send({6'h00, 2'h2, 13'h0000, 3'h3});
      settle();
      chk("status high", {23'h0, lk}, 24'h000001);
      pdn = 1'b1;
      settle();
      chk("power down", {23'h0, pd}, 24'h000001);
      chk("status off", {23'h0, lk}, 24'h000000);
      pdn = 1'b0;
      settle();
      chk("power up", {23'h0, pd}, 24'h000000);
      $display("lock and power test done");
   endtask : t_lock
   task automatic t_freeze;
      cke = 1'b0;
      pdn = 1'b1;
      settle();
      chk("frozen", {23'h0, pd}, 24'h000000);
      cke = 1'b1;
      settle();
      chk("thawed", {23'h0, pd}, 24'h000001);
      pdn = 1'b0;
      settle();
      chk("running", {23'h0, pd}, 24'h000000);
      $display("clock enable test done");
   endtask : t_freeze
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   // main sequence
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_latches();
      t_limits();
      t_lock();
      t_freeze();
      close_out();
   end
endmodule : synth_serial_write_port_tb
`default_nettype wire
